/* File: dv/ccc_checker.sv */
// port assertions for the chain controller
`timescale 1ns/100ps
module ccc_checker (
    input wire CLOCK, input wire RST, input wire CHAIN_EN_N,
    input wire LOAD_COMPLETE_IN, input wire STATUS_N_IN, input wire LOAD_COMPLETE_OE,
    input wire LOAD_COMPLETE_OUT, input wire STATUS_N_OE, input wire STATUS_N_OUT,
    input wire CHAIN_EN_OUT_N, input wire USER_MODE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_enable_after_done: assert property (!CHAIN_EN_OUT_N |-> !LOAD_COMPLETE_OE)
        else $error("enable out early");
    a_release_with_enable: assert property ($fell(LOAD_COMPLETE_OE) |-> $fell(CHAIN_EN_OUT_N))
        else $error("release unpaired");
    a_user_needs_lines: assert property ($rose(USER_MODE) |-> $past(LOAD_COMPLETE_IN) && $past(STATUS_N_IN))
        else $error("user mode early");
    a_user_after_done: assert property (USER_MODE |-> !LOAD_COMPLETE_OE)
        else $error("user mode undone");
    a_done_drive_low: assert property (LOAD_COMPLETE_OE |-> !LOAD_COMPLETE_OUT)
        else $error("completion high");
    a_status_drive_low: assert property (STATUS_N_OE |-> !STATUS_N_OUT)
        else $error("status high");
    cover property ($fell(CHAIN_EN_OUT_N));
    cover property ($rose(USER_MODE));
    cover property (!CHAIN_EN_N && !LOAD_COMPLETE_OE);
endmodule // ccc_checker
bind ccc_chain_ctrl ccc_checker chk (.*);

/* File: dv/ccc_partner.sv */
// upstream chain neighbour with pulled-up shared lines
`timescale 1ns/100ps
module ccc_partner (
    input wire clk, input wire rst, input wire stall, input wire hold, input wire fault,
    input wire dut_oe, input wire stat_oe,
    output reg en_n, output wire done_ln, output wire stat_ln
);
    always @(posedge clk) begin
        en_n <= rst | hold; // upstream done, enable held low unless reset or hold
    end
    assign done_ln = !(dut_oe || stall); // upstream holds completion on stall
    assign stat_ln = !(stat_oe || fault); // neighbour error pulls shared status low
endmodule // ccc_partner

/* File: dv/tb.sv */
// self-checking bench for the chain controller
`timescale 1ns/100ps
module tb;
    reg clk = 1'b0, rst = 1'b1, config_data_clock = 1'b0, tck = 1'b0, stall = 1'b0;
    reg hold = 1'b0, fault = 1'b0;
    wire err_o;
    reg [3:0] sel = 4'h0;
    wire en_n, done_ln, stat_ln, d_oe, s_oe, en_o_n, user;
    integer err_total = 0, checks = 0, i;
    always #50 clk = ~clk;
    ccc_partner up (.clk(clk), .rst(rst), .stall(stall), .hold(hold), .fault(fault),
        .dut_oe(d_oe), .stat_oe(s_oe), .en_n(en_n), .done_ln(done_ln), .stat_ln(stat_ln));
    ccc_chain_ctrl dut (.CLOCK(clk), .RST(rst), .SCHEME_SELECT(sel), .CHAIN_EN_N(en_n),
        .SERIAL_CONFIG_IN(config_data_clock), .CONFIG_DATA_CLOCK(config_data_clock), .TCK(tck), .TDI(tck),
        .SCAN_LOAD_REQ(sel == 4'h0), .LOAD_LENGTH(24'h000008), .LOAD_COMPLETE_IN(done_ln),
        .STATUS_N_IN(stat_ln), .LOAD_COMPLETE_OE(d_oe), .LOAD_COMPLETE_OUT(), .STATUS_N_OE(s_oe),
        .STATUS_N_OUT(), .CHAIN_EN_OUT_N(en_o_n), .USER_MODE(user), .LOAD_ERROR(err_o));
    task check(input [63:0] nm, input seen, input exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("wrong value %0s expected %b seen %b", nm, exp, seen);
            end
        end
    endtask
    task complete_run;
        begin
            $display("errors %0d checks %0d", err_total, checks);
            if (err_total == 0 && checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task restart(input [3:0] s);
        begin
            rst = 1'b1;
            sel = s;
            repeat (10) @(negedge clk);
            rst = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task pulse(input scan, input integer n);
        begin
            repeat (n) begin
                @(negedge clk) if (scan) tck = 1'b1; else config_data_clock = 1'b1;
                @(negedge clk) {tck, config_data_clock} = 2'b00;
            end
        end
    endtask
    task wait_done;
        begin
            i = 0;
            while (en_o_n !== 1'b0 && i < 40) begin
                @(negedge clk) i = i + 1;
            end
            if (i == 40) begin
                err_total = err_total + 1;
                complete_run;
            end
        end
    endtask
    task serial_schemes;
        integer s;
        begin
            for (s = 1; s < 4; s = s + 1) begin
                restart(s[3:0]);
                pulse(1'b1, 8);
                repeat (2) @(negedge clk);
                check("scanoff", en_o_n, 1'b1);
                pulse(1'b0, 8);
                wait_done;
                repeat (3) @(negedge clk);
                check("user", user, 1'b1);
            end
        end
    endtask
    task shared_hold;
        begin
            stall = 1'b1;
            restart(4'h3);
            pulse(1'b0, 8);
            wait_done;
            repeat (3) @(negedge clk);
            check("held", user, 1'b0);
            stall = 1'b0;
        end
    endtask
    task scan_load;
        begin
            restart(4'h0);
            pulse(1'b0, 8);
            pulse(1'b1, 1101);
            check("init", en_o_n, 1'b1);
            pulse(1'b1, 1);
            check("release", en_o_n, 1'b0);
            wait_done;
            check("line", done_ln, 1'b1);
        end
    endtask
    task abort_load;
        begin
            restart(4'h3);
            pulse(1'b0, 4);
            @(negedge clk) hold = 1'b1;
            repeat (2) @(negedge clk);
            hold = 1'b0;
            repeat (3) @(negedge clk);
            pulse(1'b0, 4);
            repeat (2) @(negedge clk);
            check("restart", en_o_n, 1'b1);
            pulse(1'b0, 4);
            wait_done;
            check("enout", en_o_n, 1'b0);
        end
    endtask
    task status_fault;
        begin
            restart(4'h3);
            pulse(1'b0, 2);
            @(negedge clk) fault = 1'b1;
            repeat (2) @(negedge clk);
            fault = 1'b0;
            repeat (2) @(negedge clk);
            check("error", err_o, 1'b1);
            check("statlow", stat_ln, 1'b0);
            check("faulten", en_o_n, 1'b1);
            check("nouser", user, 1'b0);
        end
    endtask
    initial begin
        serial_schemes;
        shared_hold;
        abort_load;
        status_fault;
        scan_load;
        complete_run;
    end
endmodule // tb

/* File: verilog/ccc_chain_ctrl.v */
// chain-level configuration controller with cascade enable handshake
`timescale 1ns/100ps
`include "ccc_map.vh"
// Operation
// R1: host holds enable input low during scan load
// R2: first enable tied low, outputs feed next
// R3: own load done drives enable output low
// R4: shared completion and status lines, joint user mode
// R5: host loads all devices when lines shared
// R6: scan loads in chain order or enables grounded
// R7: scan load success drives enable output low
// R8: no chain length limit, supports over 17
// R9: separate lines suggested for scan-only use
// R10: serial input unless scan scheme uses test data
// R11: host gives 1094 extra test clocks
// R12: completion released high on scan success
module ccc_chain_ctrl (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire [3:0]  SCHEME_SELECT,
    input  wire        CHAIN_EN_N,
    input  wire        SERIAL_CONFIG_IN,
    input  wire        CONFIG_DATA_CLOCK,
    input  wire        TCK,
    input  wire        TDI,
    input  wire        SCAN_LOAD_REQ,
    input  wire [23:0] LOAD_LENGTH,
    input  wire        LOAD_COMPLETE_IN,
    input  wire        STATUS_N_IN,
    output reg         LOAD_COMPLETE_OE,
    output reg         LOAD_COMPLETE_OUT,
    output reg         STATUS_N_OE,
    output reg         STATUS_N_OUT,
    output reg         CHAIN_EN_OUT_N,
    output reg         USER_MODE,
    output reg         LOAD_ERROR
);
    // load sequencer states
    localparam ST_IDLE    = 3'h0;
    localparam ST_WAIT_EN = 3'h1;
    localparam ST_LOAD    = 3'h2;
    localparam ST_INIT    = 3'h3;
    localparam ST_USER    = 3'h4;
    localparam ST_FAIL    = 3'h5;

    reg  [2:0]              state_reg;
    reg  [2:0]              state_next;
    reg  [`CCC_LEN_W-1:0]   bits_reg;
    reg  [`CCC_LEN_W-1:0]   bits_next;
    reg  [`CCC_CNT_W-1:0]   init_reg;
    reg  [`CCC_CNT_W-1:0]   init_next;
    reg  [15:0]             crc_reg;
    reg  [15:0]             crc_next;
    reg                     scan_reg;
    reg                     scan_next;
    reg                     done_oe_next;
    reg                     done_out_next;
    reg                     stat_oe_next;
    reg                     stat_out_next;
    reg                     en_out_n_next;
    reg                     user_next;
    reg                     error_next;
    wire                    tck_rise;
    wire                    dck_rise;
    wire                    scan_mode;
    wire                    data_bit;
    wire                    bit_strobe;
    wire [`CCC_LEN_W-1:0]   target_len;
    wire [`CCC_LEN_W-1:0]   bits_inc;
    wire                    last_bit;
    wire                    init_last;

    ccc_edge u_tck (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (TCK),
        .rise (tck_rise)
    );
    ccc_edge u_dck (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (CONFIG_DATA_CLOCK),
        .rise (dck_rise)
    );

    // strobe and data follow the scheme latched at load start
    assign scan_mode  = (SCHEME_SELECT == `CCC_SEL_SCAN) | SCAN_LOAD_REQ;
    assign data_bit   = scan_reg ? TDI : SERIAL_CONFIG_IN; // [R10]
    assign bit_strobe = scan_reg ? tck_rise : dck_rise;
    assign target_len = (LOAD_LENGTH == 24'h000000) ? `CCC_DEF_LEN : LOAD_LENGTH;
    assign bits_inc   = bits_reg + 24'h000001;
    assign last_bit   = (bits_inc == target_len);
    assign init_last  = tck_rise & (init_reg == `CCC_INIT_LAST); // [R11]

    function [15:0] crc_step;
        input [15:0] c;
        input        b;
        begin
            crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
        end
    endfunction

    // the device holds no chain position, so any cascade depth works [R8]
    always @* begin
        state_next    = state_reg;
        bits_next     = bits_reg;
        init_next     = init_reg;
        crc_next      = crc_reg;
        scan_next     = scan_reg;
        done_oe_next  = LOAD_COMPLETE_OE;
        done_out_next = LOAD_COMPLETE_OUT;
        stat_oe_next  = STATUS_N_OE;
        stat_out_next = STATUS_N_OUT;
        en_out_n_next = CHAIN_EN_OUT_N;
        user_next     = USER_MODE;
        error_next    = LOAD_ERROR;
        case (state_reg)
            ST_IDLE: begin
                stat_oe_next  = 1'b0;
                stat_out_next = 1'b1;
                state_next    = ST_WAIT_EN;
            end

            ST_WAIT_EN: begin
                if (!CHAIN_EN_N) begin // [R1]
                    scan_next  = scan_mode;
                    bits_next  = {`CCC_LEN_W{1'b0}};
                    crc_next   = 16'hFFFF;
                    state_next = ST_LOAD;
                end
            end

            ST_LOAD: begin
                // enable lost mid-load restarts the count
                if (CHAIN_EN_N) begin
                    state_next = ST_WAIT_EN;
                end else if (!STATUS_N_IN) begin
                    state_next = ST_FAIL;
                end else if (bit_strobe) begin
                    crc_next  = crc_step(crc_reg, data_bit);
                    bits_next = bits_inc;
                    if (last_bit) begin
                        init_next  = {`CCC_CNT_W{1'b0}};
                        state_next = ST_INIT;
                    end
                end
            end

            ST_INIT: begin
                // init clocks counted only on scan loads [R11]
                if (!scan_reg || init_last) begin
                    done_oe_next  = 1'b0; // [R12]
                    en_out_n_next = 1'b0; // [R3] [R7]
                    state_next    = ST_USER;
                end else if (tck_rise) begin
                    init_next = init_reg + 11'h001;
                end
            end

            ST_USER: begin
                // user mode waits for the shared lines of the whole chain [R4]
                user_next = LOAD_COMPLETE_IN & STATUS_N_IN;
                if (!STATUS_N_IN) begin
                    state_next = ST_FAIL;
                end
            end

            ST_FAIL: begin
                // fail holds both shared lines low until reset
                error_next    = 1'b1;
                user_next     = 1'b0;
                done_oe_next  = 1'b1;
                stat_oe_next  = 1'b1;
                stat_out_next = 1'b0;
                en_out_n_next = 1'b1;
            end

            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state and datapath registers
    always @(posedge CLOCK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            bits_reg  <= {`CCC_LEN_W{1'b0}};
            init_reg  <= {`CCC_CNT_W{1'b0}};
            crc_reg   <= 16'h0000;
            scan_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            bits_reg  <= bits_next;
            init_reg  <= init_next;
            crc_reg   <= crc_next;
            scan_reg  <= scan_next;
        end
    end

    // open-drain drives and status flags, all registered
    always @(posedge CLOCK) begin
        if (RST) begin
            LOAD_COMPLETE_OE  <= 1'b1;
            LOAD_COMPLETE_OUT <= 1'b0;
            STATUS_N_OE       <= 1'b1;
            STATUS_N_OUT      <= 1'b0;
            CHAIN_EN_OUT_N    <= 1'b1;
            USER_MODE         <= 1'b0;
            LOAD_ERROR        <= 1'b0;
        end else begin
            LOAD_COMPLETE_OE  <= done_oe_next;
            LOAD_COMPLETE_OUT <= done_out_next;
            STATUS_N_OE       <= stat_oe_next;
            STATUS_N_OUT      <= stat_out_next;
            CHAIN_EN_OUT_N    <= en_out_n_next;
            USER_MODE         <= user_next;
            LOAD_ERROR        <= error_next;
        end
    end
endmodule // ccc_chain_ctrl

/* File: verilog/ccc_edge.v */
// rising-edge detector for a synchronous strobe input
`timescale 1ns/100ps
module ccc_edge (
    input  wire clk,
    input  wire rst,
    input  wire din,
    output wire rise
);
    reg prev_reg;
    always @(posedge clk) begin
        if (rst) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= din;
        end
    end
    assign rise = din & ~prev_reg;
endmodule // ccc_edge

/* File: verilog/ccc_map.vh */
// constants for the chain-cascade configuration controller
`ifndef CCC_MAP_VH
`define CCC_MAP_VH
`define CCC_CLK_HZ          10000000
`define CCC_INIT_TCK        1094
`define CCC_INIT_LAST       11'h445
`define CCC_SEL_W           4
`define CCC_SEL_SCAN        4'h0
`define CCC_SEL_FPP         4'h1
`define CCC_SEL_AS          4'h2
`define CCC_SEL_PS          4'h3
`define CCC_CNT_W           11
`define CCC_LEN_W           24
`define CCC_DEF_LEN         24'h000040
`define CCC_MIN_CHAIN       17
`endif
